/* File: core/flash_port_dev.sv */
/*
 * Flash block end of the user port: array, page buffer, block tracking, protection,
 * wear counts, status and optional output pipeline.
 * Assumes one clock shared with the user logic and requests only while busy is low.
 */
`include "flash_port_defs.svh"
module flash_port_dev #(
    parameter int SECTORS = `FL_SECTORS,
    parameter int PROG_CYCLES = `FL_PROG_CYCLES,
    parameter int LOAD_CYCLES = `FL_LOAD_CYCLES,
    parameter int WEAR_LIMIT = `FL_WEAR_LIMIT,
    parameter int CNT_W = 20
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Link to the user logic.
    flash_if.dev port,
    // Hold-off towards the JTAG side.
    output logic o_jtag_hold
);
    localparam int NPAGES = SECTORS * `FL_PAGES_PER_SECT;
    localparam int PW = `FL_PAGE_BYTES * 8;
    localparam int IW = $clog2(NPAGES);
    localparam int WCW = `FL_WC_W;

    if (SECTORS < 1 || SECTORS > 64 || PROG_CYCLES >= 2 ** CNT_W || LOAD_CYCLES < 1
        || PROG_CYCLES < 1 || WEAR_LIMIT >= 2 ** WCW) begin : g_bad_param
        $error("flash_port_dev: unsupported parameter values");
    end

    function automatic logic [IW-1:0] page_of(input logic [`FL_ADDR_W-1:0] a,
                                              input logic spare);
        int s;
        s = int'(a[`FL_SECT_LSB +: `FL_SECT_W]) * `FL_PAGES_PER_SECT
            + (spare ? `FL_SPARE_PAGE : int'(a[`FL_PAGE_LSB +: `FL_PAGE_W]));
        return IW'(s);
    endfunction : page_of

    function automatic int nbytes(input logic [1:0] size);
        return (size == `FL_SIZE_1B) ? 1 : ((size == `FL_SIZE_2B) ? 2 : 4);
    endfunction : nbytes

    function automatic int off_of(input logic [`FL_ADDR_W-1:0] a, input logic aux,
                                  input logic [1:0] size);
        int o;
        o = aux ? `FL_AUX_BASE + int'(a[1:0]) : int'(a[6:0]);
        if (size == `FL_SIZE_2B) begin
            o = o & ~1;
        end else if (size[1]) begin
            o = o & ~3;
        end
        return o;
    endfunction : off_of

    flash_port_pkg::dev_state_e st_q, st_d;
    flash_port_pkg::req_s req_q, req_d, live, cur;
    logic [CNT_W-1:0] cnt_q, cnt_d, w;
    logic [PW-1:0] pb_q, pb_d, src, pbw;
    logic pb_vld_q, pb_vld_d, pb_mod_q, pb_mod_d, pb_unp_q, pb_unp_d;
    logic [IW-1:0] pb_pg_q, pb_pg_d, t, dst;
    logic [3:0] blk_q, blk_d, bi;
    logic [31:0] rd_q, rd_d, rdp_q, rdv;
    logic [1:0] sts_q, sts_d, stsp_q, res;
    logic [`FL_ADDR_W-1:0] nxt_q, nxt_d;
    logic hold_q;
    logic same, rsv, pblk, fire;
    logic [WCW-1:0] wc1;
    int off;
    // Nonvolatile contents are flip-flops here, so reset also clears them.
    logic [PW-1:0] arr_q [NPAGES];
    logic [WCW-1:0] wc_q [NPAGES];
    logic [NPAGES-1:0] prot_q;
    logic arr_we, prot_wd;
    logic [PW-1:0] arr_wd;
    logic [WCW-1:0] wc_wd;

    always_comb begin
        live = '0;
        live.addr = port.addr;
        live.aux = port.extra_block_select;
        live.spare = port.reserve_page_select;
        live.size = port.access_size_sel;
        live.wdata = port.write_bus_in;
        live.redirect = port.redirect_page;
        live.setprot = port.set_protection;
        // Fixed priority when several commands are raised together.
        if (port.read_req) begin
            live.op = port.page_info_select ? flash_port_pkg::OP_PSTAT :
                      (port.sequential_fetch ? flash_port_pkg::OP_RNEXT :
                       flash_port_pkg::OP_READ);
        end else if (port.write_req) begin
            live.op = flash_port_pkg::OP_WRITE;
        end else if (port.page_clear_cmd) begin
            live.op = flash_port_pkg::OP_ERASE;
        end else if (port.program_cmd) begin
            live.op = flash_port_pkg::OP_PROG;
        end else if (port.release_protection_cmd) begin
            live.op = flash_port_pkg::OP_UNPROT;
        end else if (port.buffer_drop_cmd) begin
            live.op = flash_port_pkg::OP_DROP;
        end
    end

    always_comb begin
        cur = (st_q == flash_port_pkg::DEV_IDLE) ? live : req_q;
        if (cur.op == flash_port_pkg::OP_RNEXT) begin
            cur.addr = nxt_q;
        end
        t = page_of(cur.addr, cur.spare);
        off = off_of(cur.addr, cur.aux, cur.size);
        bi = {cur.aux, cur.aux ? 3'h0 : cur.addr[6:4]};
        same = pb_vld_q && (pb_pg_q == t);
        src = same ? pb_q : arr_q[t];
        rsv = cur.spare && (cur.addr[`FL_SECT_LSB +: `FL_SECT_W] == '0);
        dst = (cur.op == flash_port_pkg::OP_PROG && !cur.redirect) ? pb_pg_q : t;
        pblk = prot_q[dst] && !(pb_unp_q && pb_vld_q && dst == pb_pg_q);
        wc1 = wc_q[dst] + 1'b1;
        w = '0;
        res = `FL_ST_OK;
        rdv = '0;
        pbw = src;
        case (cur.op)
            flash_port_pkg::OP_READ, flash_port_pkg::OP_RNEXT: begin
                for (int b = 0; b < 4; b++) begin
                    if (b < nbytes(cur.size) && !rsv) begin
                        rdv[8*b +: 8] = src[8*(off+b) +: 8];
                    end
                end
            end
            flash_port_pkg::OP_PSTAT: begin
                rdv[`FL_PST_PROT] = prot_q[t];
                rdv[`FL_PST_MOD] = pb_mod_q && same;
                rdv[`FL_PST_UNPROT] = pb_unp_q && same;
                rdv[`FL_PST_WC_LSB +: WCW] = wc_q[t];
            end
            flash_port_pkg::OP_WRITE: begin
                if (rsv || pblk) begin
                    res = `FL_ST_PROT;
                end else if (port.buffer_guard && pb_mod_q && pb_vld_q && !same) begin
                    res = `FL_ST_LOSS;
                end else if (!same) begin
                    w = CNT_W'(LOAD_CYCLES);
                end else if (blk_q != bi) begin
                    w = CNT_W'(`FL_SWAP_CYCLES) + CNT_W'(port.pipe_stage);
                end
                for (int b = 0; b < 4; b++) begin
                    if (b < nbytes(cur.size)) begin
                        pbw[8*(off+b) +: 8] = cur.wdata[8*b +: 8];
                    end
                end
            end
            flash_port_pkg::OP_ERASE: begin
                if (rsv || pblk) begin
                    res = `FL_ST_PROT;
                end else begin
                    w = CNT_W'(PROG_CYCLES);
                end
            end
            flash_port_pkg::OP_PROG: begin
                if (!pb_vld_q || (!pb_mod_q && !cur.setprot) || pblk
                    || (!cur.redirect && t != pb_pg_q)) begin
                    res = `FL_ST_PROT;
                end else begin
                    w = CNT_W'(PROG_CYCLES);
                end
            end
            flash_port_pkg::OP_UNPROT: begin
                w = CNT_W'(LOAD_CYCLES);
            end
            default: begin
            end
        endcase
        fire = (st_q == flash_port_pkg::DEV_IDLE) ?
               (live.op != flash_port_pkg::OP_NONE && w == '0) : (cnt_q == CNT_W'(1));
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        req_d = req_q;
        pb_d = pb_q;
        pb_vld_d = pb_vld_q;
        pb_mod_d = pb_mod_q;
        pb_unp_d = pb_unp_q;
        pb_pg_d = pb_pg_q;
        blk_d = blk_q;
        rd_d = rd_q;
        sts_d = sts_q;
        nxt_d = nxt_q;
        arr_we = 1'b0;
        arr_wd = pb_q;
        prot_wd = 1'b0;
        wc_wd = wc1;
        if (st_q == flash_port_pkg::DEV_IDLE) begin
            if (live.op != flash_port_pkg::OP_NONE && w != '0) begin
                st_d = flash_port_pkg::DEV_WAIT;
                cnt_d = w;
                req_d = live;
            end
        end else begin
            cnt_d = cnt_q - 1'b1;
            if (cnt_q == CNT_W'(1)) begin
                st_d = flash_port_pkg::DEV_IDLE;
            end
        end
        if (fire) begin
            sts_d = res;
            if (res == `FL_ST_OK) begin
                case (cur.op)
                    flash_port_pkg::OP_READ, flash_port_pkg::OP_RNEXT: begin
                        // No bit errors are injected here, so reads complete with 00.
                        rd_d = rdv;
                        nxt_d = cur.addr + `FL_ADDR_W'(nbytes(cur.size));
                    end
                    flash_port_pkg::OP_PSTAT: begin
                        rd_d = rdv;
                    end
                    flash_port_pkg::OP_WRITE: begin
                        pb_d = pbw;
                        pb_vld_d = 1'b1;
                        pb_pg_d = t;
                        pb_mod_d = 1'b1;
                        blk_d = bi;
                        pb_unp_d = same && pb_unp_q;
                    end
                    flash_port_pkg::OP_ERASE: begin
                        arr_we = 1'b1;
                        arr_wd = '0;
                        pb_vld_d = 1'b0;
                        pb_mod_d = 1'b0;
                        pb_unp_d = 1'b0;
                        sts_d = (int'(wc1) > WEAR_LIMIT) ? `FL_ST_WEAR : `FL_ST_OK;
                    end
                    flash_port_pkg::OP_PROG: begin
                        arr_we = 1'b1;
                        prot_wd = cur.setprot;
                        pb_pg_d = dst;
                        pb_mod_d = 1'b0;
                        pb_unp_d = 1'b0;
                        sts_d = (int'(wc1) > WEAR_LIMIT) ? `FL_ST_WEAR : `FL_ST_OK;
                    end
                    flash_port_pkg::OP_UNPROT: begin
                        pb_d = src;
                        pb_vld_d = 1'b1;
                        pb_pg_d = t;
                        pb_mod_d = 1'b0;
                        pb_unp_d = 1'b1;
                    end
                    flash_port_pkg::OP_DROP: begin
                        pb_vld_d = 1'b0;
                        pb_mod_d = 1'b0;
                        pb_unp_d = 1'b0;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= flash_port_pkg::DEV_IDLE;
            cnt_q <= '0;
            req_q <= '0;
            pb_q <= '0;
            pb_vld_q <= 1'b0;
            pb_mod_q <= 1'b0;
            pb_unp_q <= 1'b0;
            pb_pg_q <= '0;
            blk_q <= '0;
            rd_q <= '0;
            rdp_q <= '0;
            sts_q <= `FL_ST_OK;
            stsp_q <= `FL_ST_OK;
            nxt_q <= '0;
            hold_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            req_q <= req_d;
            pb_q <= pb_d;
            pb_vld_q <= pb_vld_d;
            pb_mod_q <= pb_mod_d;
            pb_unp_q <= pb_unp_d;
            pb_pg_q <= pb_pg_d;
            blk_q <= blk_d;
            rd_q <= rd_d;
            rdp_q <= rd_q;
            sts_q <= sts_d;
            stsp_q <= sts_q;
            nxt_q <= nxt_d;
            hold_q <= port.fabric_ownership_flag;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NPAGES; i++) begin
                arr_q[i] <= '0;
                wc_q[i] <= '0;
            end
            prot_q <= '0;
        end else if (arr_we) begin
            arr_q[dst] <= arr_wd;
            wc_q[dst] <= wc_wd;
            prot_q[dst] <= prot_wd;
        end
    end

    assign port.busy = (st_q == flash_port_pkg::DEV_WAIT);
    assign port.read_bus_out = port.pipe_stage ? rdp_q : rd_q;
    assign port.status = port.pipe_stage ? stsp_q : sts_q;
    assign o_jtag_hold = hold_q;
endmodule : flash_port_dev

/* File: core/flash_port_defs.svh */
/*
 * Constants for the flash user port: address fields, page geometry, status codes,
 * page-status read layout and timing counts.
 * Assumes a 100 MHz interface clock; included by its bare name.
 */
`ifndef FLASH_PORT_DEFS_SVH
`define FLASH_PORT_DEFS_SVH
`define FL_ADDR_W 18
`define FL_SECT_LSB 12
`define FL_SECT_W 6
`define FL_PAGE_LSB 7
`define FL_PAGE_W 5
`define FL_BLK_LSB 4
`define FL_SECTORS 64
`define FL_PAGES_PER_SECT 33
`define FL_SPARE_PAGE 32
`define FL_AUX_BASE 128
`define FL_PAGE_BYTES 132
`define FL_SIZE_1B 2'h0
`define FL_SIZE_2B 2'h1
`define FL_ST_OK 2'h0
`define FL_ST_PROT 2'h1
`define FL_ST_LOSS 2'h3
`define FL_ST_WEAR 2'h3
`define FL_PST_PROT 0
`define FL_PST_MOD 1
`define FL_PST_UNPROT 2
`define FL_PST_WC_LSB 16
`define FL_WC_W 16
`define FL_CLK_NS 10
`define FL_PROG_TIME_NS 8000000
`define FL_PROG_CYCLES (`FL_PROG_TIME_NS / `FL_CLK_NS)
`define FL_LOAD_CYCLES 33
`define FL_SWAP_CYCLES 4
`define FL_WEAR_LIMIT 10000
`endif

/* File: core/flash_port_pkg.sv */
/*
 * Types shared by both ends of the flash user port.
 * Assumes flash_port_defs.svh is on the include path.
 */
`include "flash_port_defs.svh"
package flash_port_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_READ, OP_PSTAT, OP_RNEXT, OP_WRITE, OP_ERASE, OP_PROG, OP_UNPROT, OP_DROP
    } op_e;
    typedef enum logic {DEV_IDLE, DEV_WAIT} dev_state_e;
    typedef enum logic [1:0] {USR_IDLE, USR_ISSUE, USR_WAIT, USR_PIPE} usr_state_e;
    typedef struct packed {
        op_e op;
        logic [`FL_ADDR_W-1:0] addr;
        logic aux;
        logic spare;
        logic [1:0] size;
        logic [31:0] wdata;
        logic redirect;
        logic setprot;
    } req_s;
endpackage : flash_port_pkg

/* File: core/flash_if.sv */
/*
 * Signals between the flash block and the user fabric logic.
 * Assumes both ends run on the same rising clock edge.
 */
`include "flash_port_defs.svh"
interface flash_if;
    logic [`FL_ADDR_W-1:0] addr;
    logic extra_block_select;
    logic reserve_page_select;
    logic [1:0] access_size_sel;
    logic [31:0] write_bus_in;
    logic read_req;
    logic write_req;
    logic page_clear_cmd;
    logic program_cmd;
    logic release_protection_cmd;
    logic buffer_drop_cmd;
    logic redirect_page;
    logic set_protection;
    logic page_info_select;
    logic sequential_fetch;
    logic buffer_guard;
    logic pipe_stage;
    logic fabric_ownership_flag;
    logic [31:0] read_bus_out;
    logic busy;
    logic [1:0] status;
    modport dev(
        input addr, extra_block_select, reserve_page_select, access_size_sel, write_bus_in,
        input read_req, write_req, page_clear_cmd, program_cmd, release_protection_cmd,
        input buffer_drop_cmd, redirect_page, set_protection, page_info_select,
        input sequential_fetch, buffer_guard, pipe_stage, fabric_ownership_flag,
        output read_bus_out, busy, status
    );
    modport usr(
        output addr, extra_block_select, reserve_page_select, access_size_sel, write_bus_in,
        output read_req, write_req, page_clear_cmd, program_cmd, release_protection_cmd,
        output buffer_drop_cmd, redirect_page, set_protection, page_info_select,
        output sequential_fetch, buffer_guard, pipe_stage, fabric_ownership_flag,
        input read_bus_out, busy, status
    );
endinterface : flash_if

/* File: core/flash_port_usr.sv */
/*
 * User fabric end of the flash port: takes one command at a time, issues it when
 * the block is idle, and returns read data and status.
 * Assumes the same clock as the flash block.
 */
`include "flash_port_defs.svh"
module flash_port_usr (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Command port.
    input wire logic i_cmd_valid,
    input wire flash_port_pkg::op_e i_cmd_op,
    input wire logic [`FL_ADDR_W-1:0] i_cmd_addr,
    input wire logic i_cmd_aux,
    input wire logic i_cmd_spare,
    input wire logic [1:0] i_cmd_size,
    input wire logic [31:0] i_cmd_wdata,
    input wire logic i_cmd_redirect,
    input wire logic i_cmd_setprot,
    output logic o_cmd_ready,
    // Static configuration.
    input wire logic i_buffer_guard,
    input wire logic i_pipe_stage,
    // Results.
    output logic o_done,
    output logic [31:0] o_rdata,
    output logic [1:0] o_status,
    // Link to the flash block.
    flash_if.usr port
);
    flash_port_pkg::usr_state_e st_q, st_d;
    flash_port_pkg::req_s req_q, req_d;
    logic done_q, done_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] status_q, status_d;
    logic issue;

    always_comb begin
        st_d = st_q;
        req_d = req_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        status_d = status_q;
        o_cmd_ready = (st_q == flash_port_pkg::USR_IDLE) && !port.busy;
        case (st_q)
            flash_port_pkg::USR_IDLE: begin
                if (i_cmd_valid && o_cmd_ready && i_cmd_op != flash_port_pkg::OP_NONE) begin
                    req_d.op = i_cmd_op;
                    req_d.addr = i_cmd_addr;
                    req_d.aux = i_cmd_aux;
                    req_d.spare = i_cmd_spare;
                    req_d.size = i_cmd_size;
                    req_d.redirect = i_cmd_redirect;
                    req_d.setprot = i_cmd_setprot;
                    // Unused write lanes are driven low.
                    req_d.wdata = (i_cmd_size == `FL_SIZE_1B) ? {24'h0, i_cmd_wdata[7:0]} :
                                  (i_cmd_size == `FL_SIZE_2B) ? {16'h0, i_cmd_wdata[15:0]} :
                                  i_cmd_wdata;
                    st_d = flash_port_pkg::USR_ISSUE;
                end
            end
            flash_port_pkg::USR_ISSUE: begin
                st_d = flash_port_pkg::USR_WAIT;
            end
            flash_port_pkg::USR_WAIT: begin
                if (!port.busy) begin
                    st_d = i_pipe_stage ? flash_port_pkg::USR_PIPE : flash_port_pkg::USR_IDLE;
                    if (!i_pipe_stage) begin
                        done_d = 1'b1;
                        rdata_d = port.read_bus_out;
                        status_d = port.status;
                    end
                end
            end
            flash_port_pkg::USR_PIPE: begin
                st_d = flash_port_pkg::USR_IDLE;
                done_d = 1'b1;
                rdata_d = port.read_bus_out;
                status_d = port.status;
            end
            default: begin
                st_d = flash_port_pkg::USR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= flash_port_pkg::USR_IDLE;
            req_q <= '0;
            done_q <= 1'b0;
            rdata_q <= '0;
            status_q <= `FL_ST_OK;
        end else begin
            st_q <= st_d;
            req_q <= req_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            status_q <= status_d;
        end
    end

    assign issue = (st_q == flash_port_pkg::USR_ISSUE);
    assign port.addr = req_q.addr;
    assign port.extra_block_select = req_q.aux;
    assign port.reserve_page_select = req_q.spare;
    assign port.access_size_sel = req_q.size;
    assign port.write_bus_in = req_q.wdata;
    assign port.read_req = issue && (req_q.op == flash_port_pkg::OP_READ
        || req_q.op == flash_port_pkg::OP_PSTAT || req_q.op == flash_port_pkg::OP_RNEXT);
    assign port.page_info_select = issue && req_q.op == flash_port_pkg::OP_PSTAT;
    assign port.sequential_fetch = issue && req_q.op == flash_port_pkg::OP_RNEXT;
    assign port.write_req = issue && req_q.op == flash_port_pkg::OP_WRITE;
    assign port.page_clear_cmd = issue && req_q.op == flash_port_pkg::OP_ERASE;
    assign port.program_cmd = issue && req_q.op == flash_port_pkg::OP_PROG;
    assign port.release_protection_cmd = issue && req_q.op == flash_port_pkg::OP_UNPROT;
    assign port.buffer_drop_cmd = issue && req_q.op == flash_port_pkg::OP_DROP;
    assign port.redirect_page = issue && req_q.redirect;
    assign port.set_protection = issue && req_q.setprot;
    assign port.buffer_guard = i_buffer_guard;
    assign port.pipe_stage = i_pipe_stage;
    // Ownership is claimed for the whole life of a command, so JTAG never interleaves.
    assign port.fabric_ownership_flag = (st_q != flash_port_pkg::USR_IDLE);
    assign o_done = done_q;
    assign o_rdata = rdata_q;
    assign o_status = status_q;
endmodule : flash_port_usr

/* File: verification/flash_link_props.sv */
/* Timing checks on the link between the flash block and the user logic.
   Assumes one clock domain and the link signals passed in by name. */
module flash_link_props (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Link signals.
    input wire logic read_req,
    input wire logic write_req,
    input wire logic program_cmd,
    input wire logic buffer_drop_cmd,
    input wire logic fabric_ownership_flag,
    input wire logic busy,
    input wire logic [1:0] status,
    input wire logic [31:0] read_bus_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic any_req = read_req || write_req || program_cmd || buffer_drop_cmd;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    own_flag_a: assert property (any_req |-> fabric_ownership_flag)
        else $error("request without ownership flag");
    no_req_busy_a: assert property (busy |-> !any_req)
        else $error("request while busy");
    status_hold_a: assert property (busy |-> $stable(status))
        else $error("status changed while busy");
    data_hold_a: assert property (busy |-> $stable(read_bus_out))
        else $error("read data changed while busy");
    busy_min_a: assert property ($rose(busy) |-> busy [*4])
        else $error("busy shorter than four cycles");
    busy_max_a: assert property ($rose(busy) |-> ##[1:40] !busy)
        else $error("busy did not end");
    read_fast_a: assert property (read_req |=> !busy)
        else $error("read raised busy");
    drop_fast_a: assert property (buffer_drop_cmd |=> !busy)
        else $error("discard raised busy");
    cover property ($fell(busy));
    cover property (read_req);
    cover property (program_cmd ##1 busy);
endmodule : flash_link_props

/* File: verification/embedded_flash_user_port_tb_top.sv */
/* Bench joining the user end and the flash end through the link interface.
   Assumes the core files are compiled first; the program time is shortened. */
module embedded_flash_user_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, guard = 1'b0;
    logic aux = 1'b0, spare = 1'b0, redir = 1'b0, sprot = 1'b0, pipe = 1'b0;
    flash_port_pkg::op_e op = flash_port_pkg::OP_NONE;
    logic [17:0] addr = 18'h0;
    logic [1:0] size = 2'h0;
    logic [31:0] wdata = 32'h0;
    logic ready, done, hold;
    logic [31:0] rdata;
    logic [1:0] stat;
    int num_errors = 0;
    int compares = 0;
    flash_if link();
    flash_port_dev #(.SECTORS(2), .PROG_CYCLES(10)) i_flash_port_dev (.i_sys_clk(clk),
        .i_rst_n(rst_n), .port(link.dev), .o_jtag_hold(hold));
    flash_port_usr i_flash_port_usr (.i_sys_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(vld),
        .i_cmd_op(op), .i_cmd_addr(addr), .i_cmd_aux(aux), .i_cmd_spare(spare),
        .i_cmd_size(size), .i_cmd_wdata(wdata), .i_cmd_redirect(redir),
        .i_cmd_setprot(sprot), .o_cmd_ready(ready), .i_buffer_guard(guard),
        .i_pipe_stage(pipe), .o_done(done), .o_rdata(rdata), .o_status(stat), .port(link.usr));
    flash_link_props i_flash_link_props (.i_sys_clk(clk), .i_rst_n(rst_n),
        .read_req(link.read_req), .write_req(link.write_req), .program_cmd(link.program_cmd),
        .buffer_drop_cmd(link.buffer_drop_cmd), .busy(link.busy), .status(link.status),
        .fabric_ownership_flag(link.fabric_ownership_flag), .read_bus_out(link.read_bus_out));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic wrap_up();
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    task automatic tmo(input logic ok);
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            wrap_up();
        end
    endtask : tmo
    task automatic cmp_st(input logic [1:0] g, input logic [1:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t status %h expected %h", $time, g, e);
        end
    endtask : cmp_st
    task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t read %h expected %h", $time, g, e);
        end
    endtask : cmp_rd
    // Flags are aux, spare, redirect, protect; unused upper read bits are masked off.
    task automatic run(input logic [3:0] o, input logic [17:0] a, input logic [1:0] sz,
        input logic [31:0] d, input logic [3:0] f, input logic [1:0] es, input logic [31:0] ed);
        int n;
        logic [31:0] m;
        m = (sz == 2'h0) ? 32'hff : ((sz == 2'h1) ? 32'hffff : 32'hffffffff);
        for (n = 0; n < 200 && ready !== 1'b1; n++) @(negedge clk);
        tmo(ready);
        op = flash_port_pkg::op_e'(o);
        addr = a;
        size = sz;
        wdata = d;
        {aux, spare, redir, sprot} = f;
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        for (n = 0; n < 200 && done !== 1'b1; n++) @(negedge clk);
        tmo(done);
        cmp_st(stat, es);
        cmp_st({1'b0, hold}, 2'h1);
        if (o == 4'h2) cmp_rd(rdata & 32'h1, ed);
        else if (o <= 4'h3) cmp_rd(rdata & m, ed);
    endtask : run
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        cmp_st({1'b0, hold}, 2'h0);
        run(4'h4, 18'h01000, 2'h2, 32'h11223344, 4'h0, 2'h0, 32'h0);
        run(4'h6, 18'h01000, 2'h0, 32'h0, 4'h0, 2'h0, 32'h0);
        run(4'h1, 18'h01003, 2'h3, 32'h0, 4'h0, 2'h0, 32'h11223344);
        run(4'h1, 18'h01001, 2'h0, 32'h0, 4'h0, 2'h0, 32'h33);
        run(4'h3, 18'h01001, 2'h0, 32'h0, 4'h0, 2'h0, 32'h22);
        run(4'h1, 18'h01003, 2'h1, 32'h0, 4'h0, 2'h0, 32'h1122);
        run(4'h4, 18'h01000, 2'h0, 32'h44, 4'h0, 2'h0, 32'h0);
        run(4'h6, 18'h01000, 2'h0, 32'h0, 4'h1, 2'h0, 32'h0);
        run(4'h2, 18'h01000, 2'h2, 32'h0, 4'h0, 2'h0, 32'h1);
        run(4'h4, 18'h01000, 2'h2, 32'h5, 4'h0, 2'h1, 32'h0);
        run(4'h7, 18'h01000, 2'h0, 32'h0, 4'h0, 2'h0, 32'h0);
        run(4'h4, 18'h01004, 2'h2, 32'h55667788, 4'h0, 2'h0, 32'h0);
        run(4'h6, 18'h01000, 2'h0, 32'h0, 4'h0, 2'h0, 32'h0);
        run(4'h2, 18'h01000, 2'h2, 32'h0, 4'h0, 2'h0, 32'h0);
        run(4'h4, 18'h01008, 2'h0, 32'h99, 4'h0, 2'h0, 32'h0);
        run(4'h6, 18'h01080, 2'h0, 32'h0, 4'h2, 2'h0, 32'h0);
        run(4'h1, 18'h01084, 2'h2, 32'h0, 4'h0, 2'h0, 32'h55667788);
        run(4'h8, 18'h01000, 2'h0, 32'h0, 4'h0, 2'h0, 32'h0);
        guard = 1'b1;
        run(4'h4, 18'h01100, 2'h0, 32'h1, 4'h0, 2'h0, 32'h0);
        run(4'h4, 18'h01180, 2'h0, 32'h1, 4'h0, 2'h3, 32'h0);
        run(4'h8, 18'h01100, 2'h0, 32'h0, 4'h0, 2'h0, 32'h0);
        run(4'h4, 18'h01180, 2'h0, 32'h1, 4'h0, 2'h0, 32'h0);
        guard = 1'b0;
        run(4'h5, 18'h01180, 2'h0, 32'h0, 4'h0, 2'h0, 32'h0);
        run(4'h4, 18'h00000, 2'h2, 32'h1, 4'h4, 2'h1, 32'h0);
        run(4'h1, 18'h00000, 2'h2, 32'h0, 4'h4, 2'h0, 32'h0);
        run(4'h4, 18'h01200, 2'h2, 32'ha5a5a5a5, 4'h8, 2'h0, 32'h0);
        run(4'h6, 18'h01200, 2'h0, 32'h0, 4'h0, 2'h0, 32'h0);
        run(4'h1, 18'h01200, 2'h2, 32'h0, 4'h8, 2'h0, 32'ha5a5a5a5);
        run(4'h6, 18'h01200, 2'h0, 32'h0, 4'h0, 2'h1, 32'h0);
        pipe = 1'b1;
        run(4'h1, 18'h01200, 2'h2, 32'h0, 4'h8, 2'h0, 32'ha5a5a5a5);
        run(4'h4, 18'h01210, 2'h0, 32'h77, 4'h0, 2'h0, 32'h0);
        run(4'h1, 18'h01210, 2'h0, 32'h0, 4'h0, 2'h0, 32'h77);
        pipe = 1'b0;
        run(4'h6, 18'h01000, 2'h0, 32'h0, 4'h0, 2'h1, 32'h0);
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        cmp_st(stat, 2'h0);
        run(4'h1, 18'h01003, 2'h2, 32'h0, 4'h0, 2'h0, 32'h0);
        wrap_up();
    end
endmodule : embedded_flash_user_port_tb_top
